// ---- hdl/hmpb_regs.svh ----
// Encodings, depths and reset values of the host/memory/PCI data buffer
`ifndef HMPB_REGS_SVH
`define HMPB_REGS_SVH

// Host drive selector codes
`define HMPB_SEL_FLOAT    2'h0
`define HMPB_SEL_ONES     2'h1
`define HMPB_SEL_PCI      2'h2
`define HMPB_SEL_MEM      2'h3

// Pattern sourced on the host bus for selector code one
`define HMPB_ALL_ONES     64'hFFFF_FFFF_FFFF_FFFF

// Queue depths
`define HMPB_H2P_DEPTH    4
`define HMPB_H2M_DEPTH    4

// Reset values and the full queue count
`define HMPB_PTR_RESET    2'h0
`define HMPB_CNT_RESET    3'h0
`define HMPB_CNT_FULL     3'h4
`define HMPB_PARERR_IDLE  1'h1
`define HMPB_STROBE_IDLE  1'h1

// Data lane layout
`define HMPB_DW_W         32
`define HMPB_QW_W         64
`define HMPB_PAR_W        8

`endif

// ---- hdl/hmpb_pkg.sv ----
// Types shared by the data buffer modules
package hmpb_pkg;

    // Every pin input, synchronised as one group
    typedef struct packed {
        logic [63:0] hostData;
        logic [63:0] memData;
        logic [7:0]  parity;
        logic [31:0] pciAd;
        logic [1:0]  hostDriveSelect;
        logic        hostToPciPush;
        logic        hostToPciPop;
        logic        hostToMemPush;
        logic        hostToMemPop;
        logic        pciPrelatchEnable;
        logic        pciSideLatchEnable_n;
        logic        memReadLatchEnable;
        logic        pciOutputEnable;
        logic        highDwordSelect;
        logic        memWriteEnable_n;
        logic        cpuResetIn;
        logic        holdAcknowledgeIn;
        logic        cpuClkIn;
        logic        pciClkIn;
    } hmpb_pins_t;

endpackage : hmpb_pkg

// ---- hdl/hmpb_data_buffer.sv ----
// Host/memory/PCI data buffer datapath with its posted write FIFO
`timescale 1ns/1ps
`include "hmpb_regs.svh"


module hmpb_fifo #(
    parameter int WIDTH = `HMPB_QW_W,
    parameter int DEPTH = `HMPB_H2M_DEPTH
) (
    input  wire logic             ref_clk,   // System clock
    input  wire logic             rst_n,     // Async reset, active low
    input  wire logic             clear,     // Sync empty
    input  wire logic             inValid,   // Write request
    output logic                  inReady,   // Space available
    input  wire logic [WIDTH-1:0] inData,    // Write data
    output logic                  outValid,  // Head valid
    input  wire logic             outReady,  // Head consumed
    output logic [WIDTH-1:0]      outData    // Head data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } hmpb_fifo_st_t;

    hmpb_fifo_st_t q_reg;
    hmpb_fifo_st_t q_next;
    logic          doPush;
    logic          doPop;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        nextPtr = (p == LAST) ? '0 : p + 1'b1;
    endfunction : nextPtr

    assign inReady  = (q_reg.cnt != FULL);
    assign outValid = (q_reg.cnt != '0);
    assign outData  = q_reg.mem[q_reg.rp];
    assign doPush   = inValid & inReady;
    assign doPop    = outReady & outValid;

    always_comb
    begin
        q_next = q_reg;
        if (doPush)
        begin
            q_next.mem[q_reg.wp] = inData;
            q_next.wp            = nextPtr(q_reg.wp);
        end
        if (doPop)
        begin
            q_next.rp = nextPtr(q_reg.rp);
        end
        if (doPush && !doPop)
        begin
            q_next.cnt = q_reg.cnt + 1'b1;
        end
        else if (doPop && !doPush)
        begin
            q_next.cnt = q_reg.cnt - 1'b1;
        end
        if (clear)
        begin
            q_next.wp  = '0;
            q_next.rp  = '0;
            q_next.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_reg <= '0;
        end
        else
        begin
            q_reg <= q_next;
        end
    end
endmodule : hmpb_fifo

module hmpb_data_buffer (
    input  wire logic           ref_clk,             // 100 MHz system clock
    input  wire logic           rst_n,               // Async reset, active low
    input  hmpb_pkg::hmpb_pins_t pins,               // Raw pin inputs
    input  wire logic           parityCheckEnable,   // Low in a system without parity
    output logic [63:0]         hostDataOut,         // Host bus drive value
    output logic                hostDataOe,          // Host bus drive enable
    output logic [63:0]         memDataOut,          // Memory bus drive value
    output logic [7:0]          memParityOut,        // Parity lane drive value
    output logic                memDataOe,           // Memory bus and lane enable
    output logic [31:0]         pciAdOut,            // PCI AD drive value
    output logic                pciAdOe,             // PCI AD drive enable
    output logic                parityError_n,       // Read parity error, active low
    output logic                hostToPciFull,       // Host-to-PCI queue full
    output logic                hostToPciEmpty,      // Host-to-PCI queue empty
    output logic                hostToMemFull,       // Host-to-memory queue full
    output logic                hostToMemEmpty       // Host-to-memory queue empty
);
    import hmpb_pkg::*;

    typedef struct packed {
        hmpb_pins_t                                  s1;
        hmpb_pins_t                                  s2;
        logic                                        cpuClkD;
        logic                                        pciClkD;
        logic                                        pushD;
        logic                                        popD;
        logic                                        memLatchEnD;
        logic [`HMPB_H2P_DEPTH-1:0][`HMPB_DW_W-1:0]  h2pQ;
        logic [1:0]                                  h2pWp;
        logic [1:0]                                  h2pRp;
        logic [2:0]                                  h2pCnt;
        logic [`HMPB_DW_W-1:0]                       prelatch;
        logic [`HMPB_QW_W-1:0]                       pciRdBuf;
        logic [`HMPB_QW_W-1:0]                       cpuRdBuf;
        logic [`HMPB_QW_W-1:0]                       p2mBuf;
        logic [`HMPB_QW_W-1:0]                       memLatch;
        logic [`HMPB_PAR_W-1:0]                      parLatch;
        logic [`HMPB_QW_W-1:0]                       hostOut;
        logic [`HMPB_QW_W-1:0]                       memOut;
        logic [`HMPB_PAR_W-1:0]                      parOut;
        logic                                        parErrN;
    } hmpb_state_t;

    hmpb_state_t st_reg;
    hmpb_state_t st_next;

    logic                   cpuEdge;
    logic                   pciEdge;
    logic                   h2mValid;
    logic                   h2mReady;
    logic [`HMPB_QW_W-1:0]  h2mHead;
    logic                   h2mHeadValid;
    logic                   h2mPop;

    // Even parity: lane bit n makes byte n plus bit even
    function automatic logic [7:0] laneParity(input logic [63:0] d);
        for (int i = 0; i < 8; i++)
        begin
            laneParity[i] = ^d[8*i +: 8];
        end
    endfunction : laneParity

    // Picks the dword half named by the high dword select
    function automatic logic [31:0] pickHalf(input logic [63:0] d, input logic hi);
        pickHalf = hi ? d[63:32] : d[31:0];
    endfunction : pickHalf

    // Slow clocks arrive as pins; their rising edges become enables
    assign cpuEdge = st_reg.s2.cpuClkIn & ~st_reg.cpuClkD;
    assign pciEdge = st_reg.s2.pciClkIn & ~st_reg.pciClkD;

    assign h2mValid = cpuEdge & st_reg.s2.hostToMemPush;
    assign h2mPop   = cpuEdge & st_reg.s2.hostToMemPop;

    hmpb_fifo #(
        .WIDTH (`HMPB_QW_W),
        .DEPTH (`HMPB_H2M_DEPTH)
    ) u_h2m (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clear    (st_reg.s2.cpuResetIn),
        .inValid  (h2mValid),
        .inReady  (h2mReady),
        .inData   (st_reg.s2.hostData),
        .outValid (h2mHeadValid),
        .outReady (h2mPop),
        .outData  (h2mHead)
    );

    always_comb
    begin
        st_next         = st_reg;
        st_next.s1      = pins;
        st_next.s2      = st_reg.s1;
        st_next.cpuClkD = st_reg.s2.cpuClkIn;
        st_next.pciClkD = st_reg.s2.pciClkIn;
        st_next.pushD   = st_reg.s2.hostToPciPush;
        st_next.popD    = st_reg.s2.hostToPciPop;
        st_next.memLatchEnD = st_reg.s2.memReadLatchEnable;

        // Host-to-PCI queue; a full push or empty pop is dropped
        if (st_reg.s2.hostToPciPush && !st_reg.pushD && st_reg.h2pCnt != `HMPB_CNT_FULL)
        begin
            st_next.h2pQ[st_reg.h2pWp] = pickHalf(st_reg.s2.hostData,
                                                  st_reg.s2.highDwordSelect);
            st_next.h2pWp  = st_reg.h2pWp + 2'h1;
            st_next.h2pCnt = st_next.h2pCnt + 3'h1;
        end
        if (st_reg.s2.hostToPciPop && !st_reg.popD && st_reg.h2pCnt != `HMPB_CNT_RESET)
        begin
            st_next.h2pRp  = st_reg.h2pRp + 2'h1;
            st_next.h2pCnt = st_next.h2pCnt - 3'h1;
        end

        // Prelatch: queue head when posted data waits, else PCI read buffer
        if (st_reg.s2.pciPrelatchEnable)
        begin
            if (st_reg.h2pCnt != `HMPB_CNT_RESET)
            begin
                st_next.prelatch = st_reg.h2pQ[st_reg.h2pRp];
            end
            else
            begin
                st_next.prelatch = pickHalf(st_reg.pciRdBuf,
                                            st_reg.s2.highDwordSelect);
            end
        end

        // PCI side latch acts on the PCI clock edge
        if (pciEdge && !st_reg.s2.pciSideLatchEnable_n)
        begin
            st_next.pciRdBuf = st_reg.s2.memReadLatchEnable ?
                               st_reg.s2.memData : st_reg.s2.hostData;
            if (st_reg.s2.highDwordSelect)
            begin
                st_next.cpuRdBuf[63:32] = st_reg.s2.pciAd;
                st_next.p2mBuf[63:32]   = st_reg.s2.pciAd;
            end
            else
            begin
                st_next.cpuRdBuf[31:0] = st_reg.s2.pciAd;
                st_next.p2mBuf[31:0]   = st_reg.s2.pciAd;
            end
        end

        // Memory read latch follows the bus while enabled
        if (st_reg.s2.memReadLatchEnable)
        begin
            st_next.memLatch = st_reg.s2.memData;
            st_next.parLatch = st_reg.s2.parity;
            st_next.parErrN  = `HMPB_PARERR_IDLE;
        end
        else if (st_reg.memLatchEnD)
        begin
            // Hold acknowledge marks a PCI master read, whose parity is ignored
            st_next.parErrN = !(parityCheckEnable && !st_reg.s2.holdAcknowledgeIn
                                && laneParity(st_reg.memLatch) != st_reg.parLatch);
        end

        // Host bus source
        unique case (st_reg.s2.hostDriveSelect)
            `HMPB_SEL_FLOAT: st_next.hostOut = st_reg.hostOut;
            `HMPB_SEL_ONES:  st_next.hostOut = `HMPB_ALL_ONES;
            `HMPB_SEL_PCI:   st_next.hostOut = st_reg.cpuRdBuf;
            `HMPB_SEL_MEM:   st_next.hostOut = st_reg.memLatch;
        endcase

        // Posted host writes go to memory before posted PCI writes
        st_next.memOut = h2mHeadValid ? h2mHead : st_reg.p2mBuf;
        st_next.parOut = laneParity(st_next.memOut);

        if (st_reg.s2.cpuResetIn)
        begin
            st_next.h2pWp  = `HMPB_PTR_RESET;
            st_next.h2pRp  = `HMPB_PTR_RESET;
            st_next.h2pCnt = `HMPB_CNT_RESET;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg         <= '0;
            st_reg.parErrN <= `HMPB_PARERR_IDLE;
            // Active-low enables idle high, so reset drives no memory bus
            st_reg.s1.memWriteEnable_n     <= `HMPB_STROBE_IDLE;
            st_reg.s2.memWriteEnable_n     <= `HMPB_STROBE_IDLE;
            st_reg.s1.pciSideLatchEnable_n <= `HMPB_STROBE_IDLE;
            st_reg.s2.pciSideLatchEnable_n <= `HMPB_STROBE_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign hostDataOut    = st_reg.hostOut;
    assign hostDataOe     = (st_reg.s2.hostDriveSelect != `HMPB_SEL_FLOAT);
    assign memDataOut     = st_reg.memOut;
    assign memParityOut   = st_reg.parOut;
    assign memDataOe      = ~st_reg.s2.memWriteEnable_n;
    assign pciAdOut       = st_reg.prelatch;
    assign pciAdOe        = st_reg.s2.pciOutputEnable;
    assign parityError_n  = st_reg.parErrN;
    assign hostToPciFull  = (st_reg.h2pCnt == `HMPB_CNT_FULL);
    assign hostToPciEmpty = (st_reg.h2pCnt == `HMPB_CNT_RESET);
    assign hostToMemFull  = ~h2mReady;
    assign hostToMemEmpty = ~h2mHeadValid;
endmodule : hmpb_data_buffer

// ---- testbench/hmpb_data_buffer_checker.sv ----
// Port assertions for the host/memory/PCI data buffer
`timescale 1ns/1ps
`include "hmpb_regs.svh"
module hmpb_data_buffer_checker (
    input wire logic            ref_clk,           // Clock
    input wire logic            rst_n,             // Reset
    input hmpb_pkg::hmpb_pins_t pins,              // Raw pins
    input wire logic            parityCheckEnable, // Parity on
    input wire logic [63:0]     hostDataOut,       // Host value
    input wire logic            hostDataOe,        // Host enable
    input wire logic            memDataOe,         // Memory enable
    input wire logic            pciAdOe,           // AD enable
    input wire logic            parityError_n,     // Parity error
    input wire logic            hostToPciFull,     // Flag
    input wire logic            hostToPciEmpty,    // Flag
    input wire logic            hostToMemFull,     // Flag
    input wire logic            hostToMemEmpty     // Flag
);
    import hmpb_pkg::*;
    logic [1:0] settled_reg;
    // Two-deep history must hold post-reset values before comparing
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            settled_reg <= 2'h0;
        else if (settled_reg != 2'h3)
            settled_reg <= settled_reg + 2'h1;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_host_oe_sel: assert property (settled_reg == 2'h3 |->
        hostDataOe == ($past(pins.hostDriveSelect, 2) != `HMPB_SEL_FLOAT))
        else $error("host enable wrong");
    a_pci_oe_follow: assert property (settled_reg == 2'h3 |->
        pciAdOe == $past(pins.pciOutputEnable, 2)) else $error("AD enable wrong");
    a_mem_oe_follow: assert property (settled_reg == 2'h3 |->
        memDataOe == !$past(pins.memWriteEnable_n, 2)) else $error("memory enable wrong");
    a_ones_drive: assert property ((pins.hostDriveSelect == `HMPB_SEL_ONES)[*5] |->
        hostDataOut == `HMPB_ALL_ONES) else $error("ones pattern missing");
    a_mem_read_path: assert property ((pins.hostDriveSelect == `HMPB_SEL_MEM &&
        pins.memReadLatchEnable && $stable(pins.memData))[*6] |-> hostDataOut == pins.memData)
        else $error("memory data not on host bus");
    a_parity_cause: assert property ($fell(parityError_n) |-> $past(parityCheckEnable) &&
        !$past(pins.memReadLatchEnable, 3) && !$past(pins.holdAcknowledgeIn, 3))
        else $error("parity error without cause");
    a_reset_empties: assert property (pins.cpuResetIn[*5] |-> hostToPciEmpty &&
        hostToMemEmpty && !hostToPciFull && !hostToMemFull) else $error("reset left data");
    a_h2p_push_cause: assert property ($fell(hostToPciEmpty) || $rose(hostToPciFull) |->
        $past(pins.hostToPciPush, 3) || $past(pins.hostToPciPush, 4))
        else $error("queue grew without push");
    a_h2m_push_cause: assert property ($fell(hostToMemEmpty) |->
        $past(pins.hostToMemPush, 3) || $past(pins.hostToMemPush, 4))
        else $error("memory queue grew without push");
    c_pci_full: cover property (hostToPciFull);
    c_mem_full: cover property (hostToMemFull);
    c_parity: cover property ($fell(parityError_n));
endmodule : hmpb_data_buffer_checker
bind hmpb_data_buffer hmpb_data_buffer_checker i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins), .parityCheckEnable(parityCheckEnable),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .memDataOe(memDataOe),
    .pciAdOe(pciAdOe), .parityError_n(parityError_n), .hostToPciFull(hostToPciFull),
    .hostToPciEmpty(hostToPciEmpty), .hostToMemFull(hostToMemFull),
    .hostToMemEmpty(hostToMemEmpty)
);

// ---- testbench/hmpb_ctrl_model.sv ----
// System controller model: host-to-PCI strobes, prelatch, AD enable
`timescale 1ns/1ps
module hmpb_ctrl_model (
    input wire logic ref_clk,  // Clock
    input wire logic full,     // Queue full
    input wire logic empty,    // Queue empty
    output logic     push,     // Push strobe
    output logic     pop,      // Pop strobe
    output logic     prelatch, // Prelatch enable
    output logic     pciOe     // AD drive enable
);
    initial {push, pop, prelatch, pciOe} = 4'h0;
    // Low phases of 3 cycles let the flags settle before the next look
    task automatic post_write();
        for (int g = 0; g < 200 && full === 1'b1; g++)
            @(negedge ref_clk);
        push = 1'b1;
        repeat (2) @(negedge ref_clk);
        push = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : post_write
    task automatic wait_empty();
        for (int g = 0; g < 200 && empty !== 1'b1; g++)
            @(negedge ref_clk);
    endtask : wait_empty
    task automatic send_entry();
        pciOe = 1'b1;
        prelatch = 1'b1;
        repeat (2) @(negedge ref_clk);
        prelatch = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : send_entry
    task automatic pop_entry();
        pciOe = 1'b0;
        pop = 1'b1;
        repeat (2) @(negedge ref_clk);
        pop = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : pop_entry
endmodule : hmpb_ctrl_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the host/memory/PCI data buffer
`timescale 1ns/1ps
`include "hmpb_regs.svh"
module testbench;
    import hmpb_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        parityCheckEnable = 1'b1;
    hmpb_pins_t  pb = '0;
    hmpb_pins_t  pinsIn;
    logic [63:0] hostDataOut, memDataOut, v;
    logic [31:0] pciAdOut, lo, hi;
    logic [7:0]  memParityOut;
    logic        hostDataOe, memDataOe, pciAdOe, parityError_n, mPush, mPop, mPre, mOe;
    logic        hostToPciFull, hostToPciEmpty, hostToMemFull, hostToMemEmpty;
    int          failures = 0, n_compared = 0, cycles = 0;
    integer      seed = 32'h3cd3c3de;
    logic [31:0] dwQ[$];
    logic [63:0] qwQ[$];
    always #5 ref_clk = ~ref_clk;
    // Wire levels: the device wins wherever it drives
    always_comb
    begin
        pinsIn = pb;
        pinsIn.hostToPciPush = mPush;
        pinsIn.hostToPciPop = mPop;
        pinsIn.pciPrelatchEnable = mPre;
        pinsIn.pciOutputEnable = mOe;
        if (hostDataOe) pinsIn.hostData = hostDataOut;
        if (memDataOe) pinsIn.memData = memDataOut;
        if (memDataOe) pinsIn.parity = memParityOut;
        if (pciAdOe) pinsIn.pciAd = pciAdOut;
    end
    hmpb_ctrl_model i_ctrl (.ref_clk(ref_clk), .full(hostToPciFull), .empty(hostToPciEmpty),
        .push(mPush), .pop(mPop), .prelatch(mPre), .pciOe(mOe));
    hmpb_data_buffer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pinsIn),
        .parityCheckEnable(parityCheckEnable), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .memDataOut(memDataOut), .memParityOut(memParityOut),
        .memDataOe(memDataOe), .pciAdOut(pciAdOut), .pciAdOe(pciAdOe),
        .parityError_n(parityError_n), .hostToPciFull(hostToPciFull),
        .hostToPciEmpty(hostToPciEmpty), .hostToMemFull(hostToMemFull),
        .hostToMemEmpty(hostToMemEmpty));
    function automatic logic [7:0] par(input logic [63:0] d);
        for (int i = 0; i < 8; i++)
            par[i] = ^d[8*i +: 8];
    endfunction : par
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic flg(input logic got, input logic exp);
        cmp({63'h0, got}, {63'h0, exp});
    endtask : flg
    // Slow clocks need at least two samples per phase
    task automatic tick(input logic pci);
        pb.pciClkIn = pci;
        pb.cpuClkIn = !pci;
        repeat (3) @(negedge ref_clk);
        pb.pciClkIn = 1'b0;
        pb.cpuClkIn = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : tick
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        pb.memWriteEnable_n = 1'b1;
        pb.pciSideLatchEnable_n = 1'b1;
        repeat (16) @(negedge ref_clk);
        flg(memDataOe, 1'b0);
        flg(pciAdOe, 1'b0);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        flg(hostToPciEmpty, 1'b1);
        flg(hostToMemEmpty, 1'b1);
        flg(parityError_n, 1'b1);
        $display("Reset test done");
        for (int i = 0; i < 4; i++)
        begin
            v = {$random(seed), $random(seed)};
            pb.hostData = v;
            pb.highDwordSelect = i[0];
            dwQ.push_back(i[0] ? v[63:32] : v[31:0]);
            i_ctrl.post_write();
        end
        flg(hostToPciFull, 1'b1);
        while (dwQ.size() > 0)
        begin
            i_ctrl.send_entry();
            cmp({32'h0, pciAdOut}, {32'h0, dwQ.pop_front()});
            flg(pciAdOe, 1'b1);
            i_ctrl.pop_entry();
        end
        flg(hostToPciEmpty, 1'b1);
        flg(pciAdOe, 1'b0);
        $display("Host-to-PCI queue test done");
        pb.hostToMemPush = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            v = {$random(seed), $random(seed)};
            pb.hostData = v;
            qwQ.push_back(v);
            tick(1'b0);
        end
        pb.hostToMemPush = 1'b0;
        flg(hostToMemFull, 1'b1);
        pb.memWriteEnable_n = 1'b0;
        pb.hostToMemPop = 1'b1;
        repeat (4) @(negedge ref_clk);
        while (qwQ.size() > 0)
        begin
            v = qwQ.pop_front();
            cmp(memDataOut, v);
            cmp({56'h0, memParityOut}, {56'h0, par(v)});
            tick(1'b0);
        end
        flg(hostToMemEmpty, 1'b1);
        pb.hostToMemPop = 1'b0;
        pb.memWriteEnable_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        flg(memDataOe, 1'b0);
        $display("Host-to-memory queue test done");
        i_ctrl.wait_empty();
        lo = $random(seed);
        hi = $random(seed);
        v = {$random(seed), $random(seed)};
        pb.hostData = v;
        pb.pciSideLatchEnable_n = 1'b0;
        for (int h = 0; h < 2; h++)
        begin
            pb.highDwordSelect = h[0];
            pb.pciAd = h ? hi : lo;
            tick(1'b1);
        end
        pb.pciSideLatchEnable_n = 1'b1;
        cmp(memDataOut, {hi, lo});
        cmp({56'h0, memParityOut}, {56'h0, par({hi, lo})});
        i_ctrl.send_entry();
        cmp({32'h0, pciAdOut}, {32'h0, v[63:32]});
        i_ctrl.pop_entry();
        flg(hostToPciEmpty, 1'b1);
        v = {$random(seed), $random(seed)};
        pb.memData = v;
        pb.parity = par(v);
        pb.memReadLatchEnable = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            pb.hostDriveSelect = s[1:0];
            repeat (6) @(negedge ref_clk);
            flg(hostDataOe, s != 0);
            if (s == 1) cmp(hostDataOut, `HMPB_ALL_ONES);
            if (s == 2) cmp(hostDataOut, {hi, lo});
            if (s == 3) cmp(hostDataOut, v);
        end
        pb.memReadLatchEnable = 1'b0;
        pb.memData = ~v;
        repeat (6) @(negedge ref_clk);
        cmp(hostDataOut, v);
        flg(parityError_n, 1'b1);
        pb.hostDriveSelect = `HMPB_SEL_FLOAT;
        $display("Host selector test done");
        for (int k = 0; k < 3; k++)
        begin
            pb.holdAcknowledgeIn = (k == 1);
            parityCheckEnable = (k != 2);
            pb.memData = {$random(seed), $random(seed)};
            pb.parity = par(pb.memData) ^ 8'h01;
            pb.memReadLatchEnable = 1'b1;
            repeat (4) @(negedge ref_clk);
            pb.memReadLatchEnable = 1'b0;
            repeat (5) @(negedge ref_clk);
            flg(parityError_n, k != 0);
        end
        $display("Parity test done");
        i_ctrl.post_write();
        i_ctrl.post_write();
        pb.hostToMemPush = 1'b1;
        tick(1'b0);
        pb.hostToMemPush = 1'b0;
        flg(hostToPciEmpty, 1'b0);
        pb.cpuResetIn = 1'b1;
        repeat (6) @(negedge ref_clk);
        flg(hostToPciEmpty, 1'b1);
        flg(hostToMemEmpty, 1'b1);
        pb.cpuResetIn = 1'b0;
        $display("CPU reset test done");
        finish_test();
    end
endmodule : testbench
